// ==== gpsel_mux.sv ====
// pin output select multiplexer for the configurable pins
`timescale 1ns/1ps
`default_nettype none
module gpsel_mux
  import gpsel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_PINS*7-1:0] pinOutputSelectCode,
  input wire logic cca,
  input wire logic demodCca,
  input wire logic sampleCcaStrobe,
  input wire logic transmitIfClearStrobe,
  input wire logic sfdSeen,
  input wire logic inRx,
  input wire logic inTx,
  input wire logic synthLock,
  input wire logic rssiUpdate,
  input wire logic randI,
  input wire logic randQ,
  input wire logic sniffClk,
  input wire logic sniffData,
  input wire logic modSerialClk,
  input wire logic modSerialData,
  input wire logic [FFC_STATE_W-1:0] frameFifoControllerState,
  input wire logic [1:0] dpuRunning,
  input wire logic [1:0] dpuPending,
  output logic [NUM_PINS-1:0] pinOut
);
  // ==========================================================================
  // only lock and sniffer/modulator inputs are synchronised, as those may be async
  logic lockS;
  logic sniffClkS;
  logic sniffDataS;
  logic modClkS;
  logic modDataS;
  gpsel_sync uSyncLock (.clk(clk), .rst_n(rst_n), .d(synthLock), .q(lockS));
  gpsel_sync uSyncSc (.clk(clk), .rst_n(rst_n), .d(sniffClk), .q(sniffClkS));
  gpsel_sync uSyncSd (.clk(clk), .rst_n(rst_n), .d(sniffData), .q(sniffDataS));
  gpsel_sync uSyncMc (.clk(clk), .rst_n(rst_n), .d(modSerialClk), .q(modClkS));
  gpsel_sync uSyncMd (.clk(clk), .rst_n(rst_n), .d(modSerialData), .q(modDataS));

  // ==========================================================================
  // random bits
  logic heldI;
  logic heldQ;
  gpsel_rand uRand (
    .clk(clk),
    .rst_n(rst_n),
    .randI(randI),
    .randQ(randQ),
    .heldI(heldI),
    .heldQ(heldQ)
  );

  // ==========================================================================
  // status flags
  logic sfdFlag;
  logic rssiValid;
  logic sampledCca;
  logic inRxD;
  logic inTxD;
  logic next_sfdFlag;
  logic next_rssiValid;
  logic next_sampledCca;
  logic leaveRx;
  logic leaveTx;

  always_comb begin
    leaveRx = inRxD && !inRx;
    leaveTx = inTxD && !inTx;
    next_sfdFlag = sfdFlag;
    // leaving clears first; a delimiter in the same cycle wins only while inRx or inTx is still high
    if (leaveRx || leaveTx) begin
      next_sfdFlag = 1'b0;
    end
    if (sfdSeen && (inRx || inTx)) begin
      next_sfdFlag = 1'b1;
    end
    next_rssiValid = rssiValid;
    if (!inRx) begin
      next_rssiValid = 1'b0;
    end else if (rssiUpdate) begin
      next_rssiValid = 1'b1;
    end
    next_sampledCca = sampledCca;
    if (sampleCcaStrobe || transmitIfClearStrobe) begin
      next_sampledCca = demodCca;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfdFlag <= 1'b0;
      rssiValid <= 1'b0;
      sampledCca <= SAMPLED_CCA_RST;
      inRxD <= 1'b0;
      inTxD <= 1'b0;
    end else begin
      sfdFlag <= next_sfdFlag;
      rssiValid <= next_rssiValid;
      sampledCca <= next_sampledCca;
      inRxD <= inRx;
      inTxD <= inTx;
    end
  end

  // ==========================================================================
  // controller state decode
  function automatic logic inRange(input logic [FFC_STATE_W-1:0] s,
                                   input logic [FFC_STATE_W-1:0] lo,
                                   input logic [FFC_STATE_W-1:0] hi);
    inRange = (s >= lo) && (s <= hi);
  endfunction : inRange

  logic rxActive;
  logic txActive;
  // the pin still passes an output flop here, so the glitches are filtered
  always_comb begin
    rxActive = inRange(frameFifoControllerState, FFC_RX_FIRST, FFC_RX_LAST);
    txActive = inRange(frameFifoControllerState, FFC_TX_FIRST, FFC_TX_LAST);
  end

  // ==========================================================================
  // per-pin select
  function automatic logic selectSignal(input logic [6:0] code,
    input logic ccaV, input logic sfdV, input logic lockV, input logic rssiV,
    input logic sCcaV, input logic rI, input logic rQ, input logic scV,
    input logic sdV, input logic mcV, input logic mdV, input logic rxV,
    input logic txV, input logic [1:0] runV, input logic [1:0] pendV);
    logic r;
    r = 1'b0;
    case (code)
      SEL_CCA: r = ccaV;
      SEL_SFD: r = sfdV;
      SEL_LOCK: r = lockV;
      SEL_RSSI_VALID: r = rssiV;
      SEL_SAMPLED_CCA: r = sCcaV;
      SEL_RAND_I: r = rI;
      SEL_RAND_Q: r = rQ;
      SEL_RAND_XOR: r = rI ^ rQ;
      SEL_SNIFF_CLK: r = scV;
      SEL_SNIFF_DATA: r = sdV;
      SEL_MOD_CLK: r = mcV;
      SEL_MOD_DATA: r = mdV;
      SEL_RX_ACTIVE: r = rxV;
      SEL_TX_ACTIVE: r = txV;
      SEL_DPU_RUN_LO: r = runV[0];
      SEL_DPU_RUN_HI: r = runV[1];
      SEL_DPU_BUSY_LO: r = runV[0] | pendV[0];
      SEL_DPU_BUSY_HI: r = runV[1] | pendV[1];
      SEL_CONST0: r = 1'b0;
      SEL_CONST1: r = 1'b1;
      default: r = 1'b0;
    endcase
    selectSignal = r;
  endfunction : selectSignal

  logic [NUM_PINS-1:0] next_pinOut;
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : gPin
      always_comb begin
        next_pinOut[p] = selectSignal(pinOutputSelectCode[p*7 +: 7], cca, sfdFlag,
          lockS, rssiValid, sampledCca, heldI, heldQ, sniffClkS, sniffDataS,
          modClkS, modDataS, rxActive, txActive, dpuRunning, dpuPending);
      end
    end
  endgenerate

  // clock and data pass the same three-flop delay (two-flop sync plus this flop), so rising-edge sampling still holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= '0;
    end else begin
      pinOut <= next_pinOut;
    end
  end
endmodule : gpsel_mux
`default_nettype wire

// ==== gpsel_pkg.sv ====
// package: select codes and timing constants for the pin output select mux
`default_nettype none
package gpsel_pkg;
  // ==========================================================================
  // select codes
  localparam logic [6:0] SEL_CCA = 7'h29;
  localparam logic [6:0] SEL_SFD = 7'h2A;
  localparam logic [6:0] SEL_LOCK = 7'h2B;
  localparam logic [6:0] SEL_RSSI_VALID = 7'h2C;
  localparam logic [6:0] SEL_SAMPLED_CCA = 7'h2D;
  localparam logic [6:0] SEL_RAND_I = 7'h2E;
  localparam logic [6:0] SEL_RAND_Q = 7'h2F;
  localparam logic [6:0] SEL_RAND_XOR = 7'h30;
  localparam logic [6:0] SEL_SNIFF_CLK = 7'h31;
  localparam logic [6:0] SEL_SNIFF_DATA = 7'h32;
  localparam logic [6:0] SEL_MOD_CLK = 7'h33;
  localparam logic [6:0] SEL_MOD_DATA = 7'h34;
  localparam logic [6:0] SEL_RX_ACTIVE = 7'h43;
  localparam logic [6:0] SEL_TX_ACTIVE = 7'h44;
  localparam logic [6:0] SEL_DPU_RUN_LO = 7'h5E;
  localparam logic [6:0] SEL_DPU_RUN_HI = 7'h5F;
  localparam logic [6:0] SEL_DPU_BUSY_LO = 7'h62;
  localparam logic [6:0] SEL_DPU_BUSY_HI = 7'h63;
  localparam logic [6:0] SEL_CONST0 = 7'h7E;
  localparam logic [6:0] SEL_CONST1 = 7'h7F;
  // ==========================================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int RAND_HZ = 8_000_000;
  localparam int RAND_DIV = CLK_HZ / RAND_HZ;
  localparam int NUM_PINS = 6;
  localparam int FFC_STATE_W = 4;
  localparam logic SAMPLED_CCA_RST = 1'b0;
  // frame fifo controller state groups
  localparam logic [FFC_STATE_W-1:0] FFC_RX_FIRST = 4'h1;
  localparam logic [FFC_STATE_W-1:0] FFC_RX_LAST = 4'h6;
  localparam logic [FFC_STATE_W-1:0] FFC_TX_FIRST = 4'h8;
  localparam logic [FFC_STATE_W-1:0] FFC_TX_LAST = 4'hD;
endpackage : gpsel_pkg
`default_nettype wire

// ==== gpsel_sync.sv ====
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module gpsel_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : gpsel_sync
`default_nettype wire

// ==== gpsel_rand.sv ====
// random bit sampler refreshed at the rand rate
`timescale 1ns/1ps
`default_nettype none
module gpsel_rand
  import gpsel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic randI,
  input wire logic randQ,
  output logic heldI,
  output logic heldQ
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_heldI;
  logic next_heldQ;
  // ==========================================================================
  // rate divider; 100/8 is not whole, rate is 8.33 MHz nominal
  always_comb begin
    next_cnt = cnt + 4'h1;
    next_heldI = heldI;
    next_heldQ = heldQ;
    if (cnt == 4'(RAND_DIV - 1)) begin
      next_cnt = 4'h0;
      next_heldI = randI;
      next_heldQ = randQ;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      heldI <= 1'b0;
      heldQ <= 1'b0;
    end else begin
      cnt <= next_cnt;
      heldI <= next_heldI;
      heldQ <= next_heldQ;
    end
  end
endmodule : gpsel_rand
`default_nettype wire

// ==== gpsel_mux_monitor.sv ====
// checker for the pin output select mux, watching pin 0
`timescale 1ns/1ps
`default_nettype none
module gpsel_mux_monitor
  import gpsel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NUM_PINS*7-1:0] pinOutputSelectCode,
  input wire logic cca,
  input wire logic demodCca,
  input wire logic sampleCcaStrobe,
  input wire logic transmitIfClearStrobe,
  input wire logic inRx,
  input wire logic [FFC_STATE_W-1:0] frameFifoControllerState,
  input wire logic [1:0] dpuRunning,
  input wire logic [NUM_PINS-1:0] pinOut
);
  // ====================
  // properties
  logic [6:0] c0;
  assign c0 = pinOutputSelectCode[6:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // past(rst_n) guards the first edge after release, where the pin is still 0
  const_one_a: assert property ($past(rst_n) && $past(c0) == SEL_CONST1 |-> pinOut[0])
    else $error("constant one missing");
  cca_route_a: assert property ($past(rst_n) && $past(c0) == SEL_CCA |->
    pinOut[0] == $past(cca)) else $error("cca not routed");
  rx_active_a: assert property ($past(rst_n) && $past(c0) == SEL_RX_ACTIVE |->
    pinOut[0] == ($past(frameFifoControllerState) inside {[FFC_RX_FIRST:FFC_RX_LAST]}))
    else $error("rx bad");
  tx_active_a: assert property ($past(rst_n) && $past(c0) == SEL_TX_ACTIVE |->
    pinOut[0] == ($past(frameFifoControllerState) inside {[FFC_TX_FIRST:FFC_TX_LAST]}))
    else $error("tx bad");
  dpu_run_a: assert property ($past(rst_n) && $past(c0) == SEL_DPU_RUN_LO |->
    pinOut[0] == $past(dpuRunning[0])) else $error("dpu run bad");
  reserved_low_a: assert property ($past(c0) inside
    {[7'h35:7'h42], [7'h45:7'h5D], [7'h60:7'h61], [7'h64:7'h7D]} |-> !pinOut[0])
    else $error("reserved code not low");
  rssi_clear_a: assert property ((!inRx && c0 == SEL_RSSI_VALID) ##1
    c0 == SEL_RSSI_VALID |=> !pinOut[0]) else $error("rssi valid outside rx");
  sampled_cca_a: assert property ((sampleCcaStrobe && c0 == SEL_SAMPLED_CCA) ##1
    (c0 == SEL_SAMPLED_CCA && !sampleCcaStrobe && !transmitIfClearStrobe)
    |=> pinOut[0] == $past(demodCca, 2)) else $error("sampled cca bad");
endmodule : gpsel_mux_monitor
bind gpsel_mux gpsel_mux_monitor mon_u (.*);
`default_nettype wire

// ==== gpsel_capture.sv ====
// capture model of the far side: shifts a data pin in on clock pin rises
`timescale 1ns/1ps
`default_nettype none
module gpsel_capture (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkPin,
  input wire logic dataPin,
  output logic [7:0] shifted
);
  // ====================
  // capture
  logic lastClk;
  // rising clock pin only, falling edges carry no data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastClk <= 1'b0;
      shifted <= 8'h00;
    end else begin
      lastClk <= clkPin;
      if (clkPin && !lastClk) begin
        shifted <= {shifted[6:0], dataPin};
      end
    end
  end
endmodule : gpsel_capture
`default_nettype wire

// ==== gpsel_mux_tb.sv ====
// self-checking bench for the pin output select mux
`timescale 1ns/1ps
`default_nettype none
module gpsel_mux_tb
  import gpsel_pkg::*;
();
  typedef struct packed {logic [6:0] c; logic [13:0] s; logic e;} gpsel_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_PINS*7-1:0] sel = {NUM_PINS{SEL_CONST1}};
  // cca lock inRx inTx randI randQ run[2] pend[2] state[4]
  logic [13:0] stim = 14'h0000;
  // demod sampleStb ticStb sfd rssiUpd serClk serData
  logic [6:0] ctl = 7'h00;
  logic [NUM_PINS-1:0] pinOut;
  logic [7:0] snifByte;
  logic [7:0] modByte;
  int bad_count = 0;
  int compares = 0;
  gpsel_row_t rows [31] = '{
    '{7'h29, 14'h2000, 1'b1}, '{7'h29, 14'h1FFF, 1'b0}, '{7'h2B, 14'h1000, 1'b1},
    '{7'h2B, 14'h2FFF, 1'b0}, '{7'h2E, 14'h0200, 1'b1}, '{7'h2F, 14'h0200, 1'b0},
    '{7'h2F, 14'h0100, 1'b1}, '{7'h30, 14'h0200, 1'b1}, '{7'h30, 14'h0300, 1'b0},
    '{7'h43, 14'h0006, 1'b1}, '{7'h43, 14'h0007, 1'b0}, '{7'h44, 14'h0008, 1'b1},
    '{7'h44, 14'h000E, 1'b0}, '{7'h5E, 14'h0040, 1'b1}, '{7'h5F, 14'h0040, 1'b0},
    '{7'h62, 14'h0010, 1'b1}, '{7'h62, 14'h0080, 1'b0}, '{7'h63, 14'h0020, 1'b1},
    '{7'h7E, 14'h3FFF, 1'b0}, '{7'h7F, 14'h0000, 1'b1}, '{7'h40, 14'h3FFF, 1'b0},
    '{7'h50, 14'h3FFF, 1'b0}, '{7'h2E, 14'h0100, 1'b0}, '{7'h5E, 14'h0080, 1'b0},
    '{7'h5F, 14'h0080, 1'b1}, '{7'h62, 14'h0040, 1'b1}, '{7'h63, 14'h0080, 1'b1},
    '{7'h63, 14'h0010, 1'b0}, '{7'h43, 14'h0001, 1'b1}, '{7'h43, 14'h0000, 1'b0},
    '{7'h44, 14'h000D, 1'b1}};
  // ====================
  // design and far side
  gpsel_mux dut_u (.clk(clk), .rst_n(rst_n), .pinOutputSelectCode(sel), .cca(stim[13]),
    .demodCca(ctl[6]), .sampleCcaStrobe(ctl[5]), .transmitIfClearStrobe(ctl[4]),
    .sfdSeen(ctl[3]), .inRx(stim[11]), .inTx(stim[10]), .synthLock(stim[12]),
    .rssiUpdate(ctl[2]), .randI(stim[9]), .randQ(stim[8]), .sniffClk(ctl[1]),
    .sniffData(ctl[0]), .modSerialClk(ctl[1]), .modSerialData(ctl[0]),
    .frameFifoControllerState(stim[3:0]), .dpuRunning(stim[7:6]), .dpuPending(stim[5:4]),
    .pinOut(pinOut));
  gpsel_capture snif_u (.clk(clk), .rst_n(rst_n), .clkPin(pinOut[0]), .dataPin(pinOut[1]),
    .shifted(snifByte));
  gpsel_capture mod_u (.clk(clk), .rst_n(rst_n), .clkPin(pinOut[2]), .dataPin(pinOut[3]),
    .shifted(modByte));
  always #5 clk = ~clk;
  // ====================
  // tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  // 16 cycles covers the slowest path, a rand refresh plus the output flop
  task automatic pin(input logic e);
    step(16);
    #1;
    check({2'b00, pinOut}, {2'b00, {NUM_PINS{e}}});
  endtask : pin
  task automatic pulse(input int k);
    @(posedge clk);
    ctl[k] <= 1'b1;
    @(posedge clk);
    ctl[k] <= 1'b0;
  endtask : pulse
  task automatic setup(input logic [6:0] c, input logic [13:0] s);
    @(posedge clk);
    sel <= {NUM_PINS{c}};
    stim <= s;
  endtask : setup
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ====================
  // sequence
  initial begin
    step(7);
    #1;
    check({2'b00, pinOut}, 8'h00); // pins low in reset
    step(1);
    rst_n <= 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      setup(rows[i].c, rows[i].s);
      pin(rows[i].e);
    end
    $display("row tests done");
    for (int k = 0; k < 2; k++) begin
      setup(SEL_SFD, k == 0 ? 14'h0800 : 14'h0400);
      pin(1'b0);
      pulse(3);
      pin(1'b1);
      setup(SEL_SFD, 14'h0000);
      pin(1'b0);
      pulse(3);
      pin(1'b0);
    end
    setup(SEL_RSSI_VALID, 14'h0800);
    pin(1'b0);
    pulse(2);
    pin(1'b1);
    setup(SEL_RSSI_VALID, 14'h0000);
    pin(1'b0);
    setup(SEL_RSSI_VALID, 14'h0800);
    pin(1'b0);
    setup(SEL_SAMPLED_CCA, 14'h0000);
    ctl[6] <= 1'b1;
    pulse(5);
    pin(1'b1);
    @(posedge clk);
    ctl[6] <= 1'b0;
    pin(1'b1);
    pulse(4);
    pin(1'b0);
    $display("flag tests done");
    // reset in mid-run must drop every pin at once, then the code applies again
    setup(SEL_CONST1, 14'h0000);
    pin(1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    step(2);
    #1;
    check({2'b00, pinOut}, 8'h00); // pins low in mid-run reset
    @(posedge clk);
    rst_n <= 1'b1;
    pin(1'b1);
    $display("mid-run reset test done");
    @(posedge clk);
    sel <= {SEL_CONST0, SEL_CONST1, SEL_MOD_DATA, SEL_MOD_CLK, SEL_SNIFF_DATA, SEL_SNIFF_CLK};
    step(8);
    // far-side clock stands low between frames
    for (int i = 7; i >= 0; i--) begin
      ctl[0] <= 1'(8'hA5 >> i);
      step(200);
      ctl[1] <= 1'b1;
      step(200);
      ctl[1] <= 1'b0;
    end
    step(8);
    check(snifByte, 8'hA5);
    check(modByte, 8'hA5);
    check({6'h00, pinOut[5:4]}, 8'h01);
    $display("serial test done");
    report_and_stop();
  end
  initial begin
    step(30000);
    bad_count++;
    report_and_stop();
  end
endmodule : gpsel_mux_tb
`default_nettype wire
